/* File: common/pts_map.svh */
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH

// Register byte addresses on the bus, one aligned word each.
`define PTS_ADR_TSEL_LO   4'h0
`define PTS_ADR_TSEL_HI   4'h4
`define PTS_ADR_STEER     4'h8
`define PTS_ADR_STATUS    4'hc

// Reset values.
`define PTS_RST_TSEL_LO   8'h00
`define PTS_RST_TSEL_HI   8'h00
`define PTS_RST_STEER     8'h01

// Field positions.
`define PTS_TSEL_HI_MASK  8'h03
`define PTS_STEER_MASK    8'h1f
`define PTS_STEER_SYNC    4
`define PTS_MODE_PWM      2'h3
`define PTS_BRIDGE_SINGLE 2'h0

// Last count of the four-clock instruction cycle.
`define PTS_INSTR_DIV     2'h3

`endif

/* File: common/pts_pkg.sv */
package pts_pkg;

	typedef enum logic [1:0] {
		PTS_PICK_ONE   = 2'h0,
		PTS_PICK_TWO   = 2'h1,
		PTS_PICK_THREE = 2'h2,
		PTS_PICK_RSVD  = 2'h3
	} pts_pick_t;

endpackage

/* File: src/pts_timer_mux.sv */
module pts_timer_mux
	import pts_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] timerPick,
	input  wire logic [2:0] periodTick,
	output logic            periodStart
);

	pts_pick_t pick;
	logic      tickSel;

	assign pick = pts_pick_t'(timerPick);

	always_comb begin
		case (pick)
			PTS_PICK_ONE:   tickSel = periodTick[0];
			PTS_PICK_TWO:   tickSel = periodTick[1];
			PTS_PICK_THREE: tickSel = periodTick[2];
			// A reserved code gives the channel no time base at all.
			default:        tickSel = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			periodStart <= 1'b0;
		else
			periodStart <= tickSel;
	end

endmodule

/* File: src/pts_pin_steer.sv */
module pts_pin_steer
	import pts_pkg::*;
#(
	parameter int POL_BIT = 1
)
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       pinEnable,
	input  wire logic       pwmRaw,
	input  wire logic [1:0] outputPolarityMode,
	output logic            pinOut,
	output logic            pinOe
);

	logic invert;

	assign invert = outputPolarityMode[POL_BIT];

	// A released pin also drives low so the port logic never sees junk.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pinOut <= 1'b0;
			pinOe  <= 1'b0;
		end else begin
			pinOut <= pinEnable & (pwmRaw ^ invert);
			pinOe  <= pinEnable;
		end
	end

endmodule

/* File: src/pts_steer_top.sv */
`include "pts_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Channel 3 takes its time base from timer three, two or one for codes 10, 01, 00.
// - Channel 2 uses the same selection from bits 3 to 2 of the low select register.
// - Channel 5 uses the same selection from bits 1 to 0 of the high select register, code 11 reserved.
// - Unused bits of the high select and steering registers ignore writes and read zero.
// - With the sync bit set, new steering enables reach the pins at the next PWM period.
// - With the sync bit clear, new steering enables reach the pins at the next instruction cycle.
// - A set steering enable drives its pin with the PWM waveform, polarity from the low mode bits.
// - A clear steering enable hands its pin back to port control.
// - Channel 4 uses the same selection from bits 7 to 6 of the low select register.
// - Steering works only in PWM function mode 11 with single output mode 00.
////////////////////////////////////////////////////////////////////////////////

module pts_steer_top
	import pts_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [2:0]  periodTick,
	input  wire logic        pwmRaw,
	input  wire logic [1:0]  outputPolarityMode,
	input  wire logic [1:0]  channelFunctionMode,
	input  wire logic [1:0]  bridgeOutputMode,
	output logic      [4:0]  chanPeriodStart,
	output logic      [3:0]  pwmPinOut,
	output logic      [3:0]  pwmPinOe
);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic [7:0]  timerSelLow_r;
	logic [7:0]  timerSelHigh_r;
	logic [7:0]  steerCtrl_r;
	logic [3:0]  steerApplied_r;
	logic [1:0]  instrCnt_r;
	logic        instrTick_r;
	logic [31:0] rdData_nxt;
	logic        busReq;
	logic        wrLane0;
	logic        hitLow;
	logic        hitHigh;
	logic        hitSteer;
	logic        hitStatus;
	logic        steerMode;
	logic        steerSync;
	logic        applyNow;
	logic [3:0]  steerPending;
	logic [3:0]  pinEnable;
	logic [1:0]  chanPick [5];

	assign busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrLane0   = busReq & wb_we_i & wb_sel_i[0];
	assign hitLow    = wb_adr_i == `PTS_ADR_TSEL_LO;
	assign hitHigh   = wb_adr_i == `PTS_ADR_TSEL_HI;
	assign hitSteer  = wb_adr_i == `PTS_ADR_STEER;
	assign hitStatus = wb_adr_i == `PTS_ADR_STATUS;

	// Unmapped addresses are still acknowledged and read as zero.
	assign rdData_nxt =
		hitLow    ? {24'h000000, timerSelLow_r} :
		hitHigh   ? {24'h000000, timerSelHigh_r} :
		hitSteer  ? {24'h000000, steerCtrl_r} :
		hitStatus ? {27'h0000000, steerMode, steerApplied_r} :
		32'h00000000;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? rdData_nxt : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			timerSelLow_r  <= `PTS_RST_TSEL_LO;
			timerSelHigh_r <= `PTS_RST_TSEL_HI;
			steerCtrl_r    <= `PTS_RST_STEER;
		end else if (wrLane0) begin
			if (hitLow)
				timerSelLow_r <= wb_dat_i[7:0];
			if (hitHigh)
				timerSelHigh_r <= wb_dat_i[7:0] & `PTS_TSEL_HI_MASK;
			if (hitSteer)
				steerCtrl_r <= wb_dat_i[7:0] & `PTS_STEER_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Time base selection per channel.

	assign chanPick[0] = timerSelLow_r[1:0];
	assign chanPick[1] = timerSelLow_r[3:2];
	assign chanPick[2] = timerSelLow_r[5:4];
	assign chanPick[3] = timerSelLow_r[7:6];
	assign chanPick[4] = timerSelHigh_r[1:0];

	for (genvar c = 0; c < 5; c++) begin : g_chan
		pts_timer_mux u_mux (
			.mclk        (mclk),
			.sys_rst     (sys_rst),
			.timerPick   (chanPick[c]),
			.periodTick  (periodTick),
			.periodStart (chanPeriodStart[c])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Steering update timing.

	// The instruction cycle is four system clocks; the tick marks its start.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			instrCnt_r  <= 2'h0;
			instrTick_r <= 1'b0;
		end else begin
			instrCnt_r  <= instrCnt_r + 2'h1;
			instrTick_r <= instrCnt_r == `PTS_INSTR_DIV;
		end
	end

	assign steerSync    = steerCtrl_r[`PTS_STEER_SYNC];
	assign steerPending = steerCtrl_r[3:0];
	// The steered channel runs on channel 1's time base.
	assign applyNow     = steerSync ? chanPeriodStart[0] : instrTick_r;

	always_ff @(posedge mclk) begin
		if (sys_rst)
			steerApplied_r <= 4'(`PTS_RST_STEER);
		else if (applyNow)
			steerApplied_r <= steerPending;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers.

	assign steerMode = channelFunctionMode == `PTS_MODE_PWM &&
		bridgeOutputMode == `PTS_BRIDGE_SINGLE;
	// Pins A and C follow mode bit 1, pins B and D follow mode bit 0.
	assign pinEnable = steerApplied_r & {4{steerMode}};

	for (genvar p = 0; p < 4; p++) begin : g_pin
		pts_pin_steer #(
			.POL_BIT (1 - (p % 2))
		) u_pin (
			.mclk               (mclk),
			.sys_rst            (sys_rst),
			.pinEnable          (pinEnable[p]),
			.pwmRaw             (pwmRaw),
			.outputPolarityMode (outputPolarityMode),
			.pinOut             (pwmPinOut[p]),
			.pinOe              (pwmPinOe[p])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_pick_chan3: assert property (@(posedge mclk) disable iff (sys_rst)
		periodTick[2] && timerSelLow_r[5:4] == 2'h2 |=> chanPeriodStart[2])
		else $error("Channel 3 missed timer three period.");

	a_pick_chan2: assert property (@(posedge mclk) disable iff (sys_rst)
		periodTick[1] && timerSelLow_r[3:2] == 2'h1 |=> chanPeriodStart[1])
		else $error("Channel 2 missed timer two period.");

	a_pick_chan5: assert property (@(posedge mclk) disable iff (sys_rst)
		timerSelHigh_r[1:0] == 2'h0 |=>
		chanPeriodStart[4] == $past(periodTick[0]))
		else $error("Channel 5 does not follow timer one.");

	a_hi_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		busReq && (hitHigh || hitSteer) |=> wb_ack_o &&
		(hitHigh ? wb_dat_o[31:2] == 30'h0 : wb_dat_o[31:5] == 27'h0))
		else $error("Unused register bits read nonzero.");

	a_sync_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		steerSync && !chanPeriodStart[0] |=> $stable(steerApplied_r))
		else $error("Steering changed outside a period start.");

	a_async_apply: assert property (@(posedge mclk) disable iff (sys_rst)
		!steerSync && instrTick_r |=>
		steerApplied_r == $past(steerPending))
		else $error("Steering not applied at instruction boundary.");

	a_pin_drive: assert property (@(posedge mclk) disable iff (sys_rst)
		steerApplied_r[1] && steerMode |=> pwmPinOe[1] &&
		pwmPinOut[1] == ($past(pwmRaw) ^ $past(outputPolarityMode[0])))
		else $error("Pin B not driven with polarity.");

	a_pin_release: assert property (@(posedge mclk) disable iff (sys_rst)
		!steerApplied_r[3] |=> !pwmPinOe[3] && !pwmPinOut[3])
		else $error("Disabled pin D still driven.");

	a_pick_chan4: assert property (@(posedge mclk) disable iff (sys_rst)
		timerSelLow_r[7:6] == 2'h3 |=> !chanPeriodStart[3])
		else $error("Channel 4 ticked on a reserved code.");

	a_mode_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		!steerMode |=> pwmPinOe == 4'h0)
		else $error("Pins steered outside single PWM mode.");

	a_pick_chan1: assert property (@(posedge mclk) disable iff (sys_rst)
		periodTick[2] && timerSelLow_r[1:0] == 2'h2 |=> chanPeriodStart[0])
		else $error("Channel 1 missed timer three period.");

	a_reset_state: assert property (@(posedge mclk)
		sys_rst |=> timerSelLow_r == 8'h00 && timerSelHigh_r == 8'h00 &&
		steerCtrl_r == 8'h01 && steerApplied_r == 4'h1)
		else $error("Reset state wrong.");

	a_res_chan5: assert property (@(posedge mclk) disable iff (sys_rst)
		timerSelHigh_r[1:0] == 2'h3 |=> !chanPeriodStart[4])
		else $error("Channel 5 ticked on a reserved code.");

	a_hi_wr_mask: assert property (@(posedge mclk) disable iff (sys_rst)
		wrLane0 && hitHigh |=> timerSelHigh_r[7:2] == 6'h00)
		else $error("Unused high select bits took a write.");

	a_steer_mask: assert property (@(posedge mclk) disable iff (sys_rst)
		wrLane0 && hitSteer |=> steerCtrl_r[7:5] == 3'h0)
		else $error("Unused steering bits took a write.");

	a_instr_tick: assert property (@(posedge mclk) disable iff (sys_rst)
		instrTick_r |=> !instrTick_r ##1 !instrTick_r ##1 !instrTick_r
		##1 instrTick_r)
		else $error("Instruction boundary not every four clocks.");

	a_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
		steerApplied_r[0] && steerMode |=> pwmPinOe[0] &&
		pwmPinOut[0] == ($past(pwmRaw) ^ $past(outputPolarityMode[1])))
		else $error("Pin A not driven with polarity.");

	a_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!steerApplied_r[0] |=> !pwmPinOe[0] && !pwmPinOut[0])
		else $error("Disabled pin A still driven.");

	a_chan4_one: assert property (@(posedge mclk) disable iff (sys_rst)
		periodTick[0] && timerSelLow_r[7:6] == 2'h0 |=> chanPeriodStart[3])
		else $error("Channel 4 missed timer one period.");

	a_res_chan1: assert property (@(posedge mclk) disable iff (sys_rst)
		timerSelLow_r[1:0] == 2'h3 |=> !chanPeriodStart[0])
		else $error("Channel 1 ticked on a reserved code.");

endmodule

/* File: dv/pts_pin_model.sv */
module pts_pin_model (
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pinOe,
	input  wire logic [3:0] portLevel,
	output logic      [3:0] padLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pad falls back to the port latch, never to the last PWM level.
	assign padLevel = (pinOe & pinOut) | (~pinOe & portLevel);
endmodule

/* File: dv/pts_steer_top_tb_top.sv */
`include "pts_map.svh"

module pts_steer_top_tb_top
	import pts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst, wbCyc, wbStb, wbWe, wbAck, pwmRaw;
	logic [3:0]  wbAdr, wbSel, pinOut, pinOe, portLevel, padLevel;
	logic [31:0] wbDatI, wbDatO;
	logic [2:0]  periodTick;
	logic [1:0]  polMode, funcMode, bridgeMode;
	logic [4:0]  chanStart;
	int          errors, numChecks, cycles;

	pts_steer_top dut (.mclk(mclk), .sys_rst(rst), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .periodTick(periodTick), .pwmRaw(pwmRaw),
		.outputPolarityMode(polMode), .channelFunctionMode(funcMode),
		.bridgeOutputMode(bridgeMode), .chanPeriodStart(chanStart),
		.pwmPinOut(pinOut), .pwmPinOe(pinOe));
	pts_pin_model pins (.pinOut(pinOut), .pinOe(pinOe),
		.portLevel(portLevel), .padLevel(padLevel));

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("Checks %0d errors %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The master never assumes a latency; the global timeout ends a hang.
	task automatic wbXfer(logic we, logic [3:0] adr, logic [7:0] d,
		output logic [31:0] q);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatI <= {24'h000000, d};
		do @(posedge mclk); while (wbAck !== 1'b1);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(logic [3:0] adr, logic [7:0] d);
		logic [31:0] q;
		wbXfer(1'b1, adr, d, q);
	endtask

	task automatic rdChk(string what, logic [3:0] adr, logic [7:0] exp);
		logic [31:0] q;
		wbXfer(1'b0, adr, 8'h00, q);
		check(what, {24'h000000, exp}, q);
	endtask

	task automatic pulse(int t);
		periodTick <= 3'h1 << t;
		@(posedge mclk);
		periodTick <= 3'h0;
		@(posedge mclk);
	endtask

	function automatic logic [3:0] expOut(logic [3:0] en, logic [1:0] pol);
		return en & ({4{pwmRaw}} ^ {pol[0], pol[1], pol[0], pol[1]});
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic testReset();
		rdChk("sel low", `PTS_ADR_TSEL_LO, 8'h00);
		rdChk("sel high", `PTS_ADR_TSEL_HI, 8'h00);
		rdChk("steer", `PTS_ADR_STEER, 8'h01);
		check("reset oe", 32'h1, {28'h0, pinOe});
	endtask

	task automatic testTimerPick();
		for (int c = 0; c < 4; c++) begin
			wr(`PTS_ADR_TSEL_LO, {4{c[1:0]}});
			wr(`PTS_ADR_TSEL_HI, {6'h00, c[1:0]});
			for (int t = 0; t < 3; t++) begin
				pulse(t);
				check("period start", (c == t) ? 32'h1f : 32'h0,
					{27'h0, chanStart});
			end
		end
		wr(`PTS_ADR_TSEL_LO, 8'h00);
	endtask

	task automatic testMasks();
		wr(`PTS_ADR_TSEL_HI, 8'hff);
		rdChk("sel high mask", `PTS_ADR_TSEL_HI, 8'h03);
		wr(`PTS_ADR_STEER, 8'hff);
		rdChk("steer mask", `PTS_ADR_STEER, 8'h1f);
		wr(`PTS_ADR_TSEL_LO, 8'he4);
		rdChk("sel low rw", `PTS_ADR_TSEL_LO, 8'he4);
		wbSel <= 4'he;
		wr(`PTS_ADR_TSEL_LO, 8'h11);
		wbSel <= 4'hf;
		rdChk("sel lane", `PTS_ADR_TSEL_LO, 8'he4);
		rdChk("unmapped", 4'h6, 8'h00);
		wr(`PTS_ADR_TSEL_LO, 8'h00);
		wr(`PTS_ADR_TSEL_HI, 8'h00);
	endtask

	task automatic testSteerNow();
		logic [3:0] en;
		for (int p = 0; p < 4; p++) begin
			en = 4'hf ^ (4'h1 << p);
			polMode <= p[1:0];
			pwmRaw <= p[1];
			wr(`PTS_ADR_STEER, {4'h0, en});
			repeat (8) @(posedge mclk);
			check("oe now", {28'h0, en}, {28'h0, pinOe});
			check("pin out", {28'h0, expOut(en, p[1:0])},
				{28'h0, pinOut});
			check("pad", {28'h0, expOut(en, p[1:0]) | (~en & portLevel)},
				{28'h0, padLevel});
		end
	endtask

	task automatic testSteerSync();
		wr(`PTS_ADR_STEER, 8'h13);
		repeat (12) @(posedge mclk);
		check("oe held", 32'h7, {28'h0, pinOe});
		pulse(0);
		repeat (2) @(posedge mclk);
		check("oe period", 32'h3, {28'h0, pinOe});
		rdChk("status", `PTS_ADR_STATUS, 8'h13);
	endtask

	task automatic testModeGate();
		funcMode <= 2'h2;
		repeat (3) @(posedge mclk);
		check("oe not pwm", 32'h0, {28'h0, pinOe});
		rdChk("status mode", `PTS_ADR_STATUS, 8'h03);
		funcMode <= `PTS_MODE_PWM;
		bridgeMode <= 2'h1;
		repeat (3) @(posedge mclk);
		check("oe bridge", 32'h0, {28'h0, pinOe});
		bridgeMode <= `PTS_BRIDGE_SINGLE;
		repeat (3) @(posedge mclk);
		check("oe back", 32'h3, {28'h0, pinOe});
	endtask

	task automatic testMidReset();
		wr(`PTS_ADR_TSEL_LO, 8'h9c);
		wr(`PTS_ADR_TSEL_HI, 8'h02);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		testReset();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI, periodTick, pwmRaw} = '0;
		{polMode, bridgeMode, errors, numChecks, cycles} = '0;
		wbSel = 4'hf;
		funcMode = `PTS_MODE_PWM;
		portLevel = 4'h5;
		rst = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		testReset();
		testTimerPick();
		testMasks();
		testSteerNow();
		testSteerSync();
		testModeGate();
		testMidReset();
		report_and_stop();
	end
endmodule
